// File: rtl/scp_params.svh
// Offsets, field positions, reset values and counts of the clock prescale block
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

// ****************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************
`define SCP_IDX_DIV_CTRL 8'h61
`define SCP_IDX_FAIL_CSR 8'h62
`define SCP_IDX_RC_TRIM 8'h66
`define SCP_IDX_TIMER_ASYNC 8'h6A

// ****************************************************************
// Field positions
// ****************************************************************
`define SCP_DIV_UNLOCK_BIT 7
`define SCP_DIV_SEL_MSB 3
`define SCP_FAIL_FLAG_BIT 1
`define SCP_FAIL_IE_BIT 0
`define SCP_TRIM_RANGE_BIT 7
`define SCP_TMR_OSC_EN_BIT 0
`define SCP_TMR_EXT_CLK_BIT 1

// ****************************************************************
// Values and counts
// ****************************************************************
`define SCP_UNLOCK_WORD 8'h80
`define SCP_SEL_RESET_NODIV 4'h0
`define SCP_SEL_RESET_DIV8 4'h3
`define SCP_SEL_MAX 4'h8
`define SCP_SRC_RC 4'h2
`define SCP_UNLOCK_CYCLES 3'h4
`define SCP_SYNC_STAGES 2

`endif

// File: rtl/scp_pkg.sv
// Types shared by the clock prescale block
`default_nettype none
package scp_pkg;

  // Fuse levels as delivered by the fuse array
  typedef struct packed {
    logic clock_output_fuse;
    logic divide_by_eight_fuse;
    logic fail_detect_fuse;
    logic [3:0] clk_src_fuse;
  } scp_fuse_t;

  // Controls sent to the oscillators and clock tree
  typedef struct packed {
    logic [3:0] clk_src_sel;
    logic fallback_active;
    logic lf_osc_enable;
    logic [7:0] rc_trim;
    logic timer_osc_enable;
    logic timer_osc_ext_clk;
  } scp_osc_ctrl_t;

  typedef enum logic [1:0] {
    SCP_INIT_SYNC,
    SCP_INIT_LOAD,
    SCP_RUN
  } scp_init_t;

endpackage
`default_nettype wire

// File: rtl/scp_clock_ctrl.sv
// System clock prescaler, RC trim, clock output and failure fallback
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scp_params.svh"

module scp_clock_ctrl #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk, // System clock, 10 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [ADDR_W-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire scp_pkg::scp_fuse_t fuses, // Fuse levels
  input wire logic [7:0] factory_trim, // Factory calibration byte
  input wire logic ext_clk_fail, // Failure seen by 128kHz detector
  input wire logic io_out, // Port logic value for the shared pin
  input wire logic io_oe, // Port logic enable for the shared pin
  output logic clock_out_pin_o, // Shared pin output value
  output logic clock_out_pin_oe, // Shared pin output enable
  output logic sys_clk_en, // Divided clock enable for CPU, flash, I/O
  output var scp_pkg::scp_osc_ctrl_t osc_ctrl, // Oscillator controls
  output logic osc_fail_req // Failure request to interrupt controller
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int SYNC_W = 7;
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;

  // Fuse levels and detector flag cross in from outside
  assign sync_in = {ext_clk_fail, fuses.divide_by_eight_fuse,
                    fuses.fail_detect_fuse, fuses.clk_src_fuse};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= sync_in;
      sync2_ff <= sync1_ff;
    end
  end

  logic fail_s;
  logic div8_fuse_s;
  logic detect_fuse_s;
  logic [3:0] src_fuse_s;
  assign fail_s = sync2_ff[6];
  assign div8_fuse_s = sync2_ff[5];
  assign detect_fuse_s = sync2_ff[4];
  assign src_fuse_s = sync2_ff[3:0];

  // Factory trim byte, two stages like the synchronised fuse levels
  logic [7:0] ftrim1_ff;
  logic [7:0] ftrim2_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ftrim1_ff <= 8'h00;
      ftrim2_ff <= 8'h00;
    end else begin
      ftrim1_ff <= factory_trim;
      ftrim2_ff <= ftrim1_ff;
    end
  end

  // ****************************************************************
  // Start-up: load fuse-derived values after the synchronisers fill
  // ****************************************************************
  scp_pkg::scp_init_t init_ff;
  logic [1:0] init_cnt_ff;
  logic load_now;
  assign load_now = (init_ff == scp_pkg::SCP_INIT_LOAD);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_ff <= scp_pkg::SCP_INIT_SYNC;
      init_cnt_ff <= 2'h0;
    end else begin
      case (init_ff)
        scp_pkg::SCP_INIT_SYNC: begin
          init_cnt_ff <= init_cnt_ff + 2'h1;
          if (init_cnt_ff == 2'(`SCP_SYNC_STAGES - 1)) begin
            init_ff <= scp_pkg::SCP_INIT_LOAD;
          end
        end
        scp_pkg::SCP_INIT_LOAD: begin
          init_ff <= scp_pkg::SCP_RUN;
        end
        default: begin
          init_ff <= scp_pkg::SCP_RUN;
        end
      endcase
    end
  end

  // ****************************************************************
  // APB slave: one wait state, registered answer
  // ****************************************************************
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
    logic [3:0] hit;
    hit = 4'h0;
    if (a == ADDR_W'({`SCP_IDX_DIV_CTRL, 2'b00})) begin
      hit = 4'h1;
    end else if (a == ADDR_W'({`SCP_IDX_FAIL_CSR, 2'b00})) begin
      hit = 4'h2;
    end else if (a == ADDR_W'({`SCP_IDX_RC_TRIM, 2'b00})) begin
      hit = 4'h4;
    end else if (a == ADDR_W'({`SCP_IDX_TIMER_ASYNC, 2'b00})) begin
      hit = 4'h8;
    end
    return hit;
  endfunction

  logic [3:0] hit;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] prdata_ff;
  logic wr_done;
  logic [7:0] wbyte;

  assign hit = decode(paddr);
  assign wbyte = pwdata[7:0];
  assign wr_done = psel && penable && pready_ff && pwrite && !pslverr_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign prdata = prdata_ff;

  // Register contents
  logic unlock_ff;
  logic [2:0] unlock_cnt_ff;
  logic [3:0] sel_ff;
  logic [7:0] trim_ff;
  logic fail_flag_ff;
  logic fail_ie_ff;
  logic fallback_ff;
  logic tosc_en_ff;
  logic tosc_ext_ff;
  logic [31:0] rd_word;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit[0]) begin
      rd_word[`SCP_DIV_UNLOCK_BIT] = unlock_ff;
      rd_word[`SCP_DIV_SEL_MSB:0] = sel_ff;
    end else if (hit[1]) begin
      rd_word[`SCP_FAIL_FLAG_BIT] = fail_flag_ff;
      rd_word[`SCP_FAIL_IE_BIT] = fail_ie_ff;
    end else if (hit[2]) begin
      rd_word[7:0] = trim_ff;
    end else if (hit[3]) begin
      rd_word[`SCP_TMR_OSC_EN_BIT] = tosc_en_ff;
      rd_word[`SCP_TMR_EXT_CLK_BIT] = tosc_ext_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (psel && penable && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= (hit == 4'h0);
      prdata_ff <= pwrite ? 32'h0000_0000 : rd_word;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Divider control: unlock window and select field
  // ****************************************************************
  logic unlock_wr;
  logic sel_wr;
  assign unlock_wr = wr_done && hit[0] && (wbyte == `SCP_UNLOCK_WORD);
  assign sel_wr = wr_done && hit[0] && unlock_ff &&
                  !wbyte[`SCP_DIV_UNLOCK_BIT];

  // Window counted in pclk cycles from the unlock write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_ff <= 1'b0;
      unlock_cnt_ff <= 3'h0;
    end else if (unlock_ff) begin
      // Rewriting the unlock word neither restarts nor clears the window
      if (sel_wr || unlock_cnt_ff == `SCP_UNLOCK_CYCLES - 3'h1) begin
        unlock_ff <= 1'b0;
        unlock_cnt_ff <= 3'h0;
      end else begin
        unlock_cnt_ff <= unlock_cnt_ff + 3'h1;
      end
    end else if (unlock_wr) begin
      unlock_ff <= 1'b1;
      unlock_cnt_ff <= 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ff <= `SCP_SEL_RESET_NODIV;
    end else if (load_now) begin
      sel_ff <= div8_fuse_s ? `SCP_SEL_RESET_DIV8
                            : `SCP_SEL_RESET_NODIV;
    end else if (sel_wr) begin
      sel_ff <= wbyte[`SCP_DIV_SEL_MSB:0];
    end
  end

  // ****************************************************************
  // Prescaler: new setting taken only at a period boundary
  // ****************************************************************
  logic [3:0] act_sel_ff;
  logic [7:0] div_cnt_ff;
  logic div_sq_ff;
  logic [7:0] last_cnt;
  logic [7:0] half_cnt;
  logic period_end;
  logic [7:0] nxt_div_cnt;
  logic [3:0] nxt_act_sel;

  // Reserved codes run at the slowest rate
  function automatic logic [7:0] top_count(input logic [3:0] s);
    logic [3:0] c;
    c = (s > `SCP_SEL_MAX) ? `SCP_SEL_MAX : s;
    return 8'((9'h001 << c) - 9'h001);
  endfunction

  assign last_cnt = top_count(act_sel_ff);
  assign half_cnt = 8'(({1'b0, last_cnt} + 9'h001) >> 1);
  assign period_end = (div_cnt_ff == last_cnt);
  // New code taken only at a period end, so no short period
  assign nxt_act_sel = period_end ? sel_ff : act_sel_ff;
  assign nxt_div_cnt = period_end ? 8'h00 : div_cnt_ff + 8'h01;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel_ff <= `SCP_SEL_RESET_NODIV;
      div_cnt_ff <= 8'h00;
    end else begin
      act_sel_ff <= nxt_act_sel;
      div_cnt_ff <= nxt_div_cnt;
    end
  end

  // Square wave high over the first half of each divided period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_sq_ff <= 1'b0;
    end else if (period_end) begin
      div_sq_ff <= (sel_ff != `SCP_SEL_RESET_NODIV);
    end else begin
      div_sq_ff <= (nxt_div_cnt < half_cnt);
    end
  end

  assign sys_clk_en = period_end;

  // ****************************************************************
  // Clock output pin
  // ****************************************************************
  logic div_out;
  assign div_out = (act_sel_ff == `SCP_SEL_RESET_NODIV) ? pclk
                                                        : div_sq_ff;
  // Fuse used raw so the pin keeps running through reset
  assign clock_out_pin_o = fuses.clock_output_fuse ? div_out : io_out;
  assign clock_out_pin_oe = fuses.clock_output_fuse | io_oe;

  // ****************************************************************
  // RC trim register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_ff <= 8'h00;
    end else if (load_now) begin
      trim_ff <= ftrim2_ff;
    end else if (wr_done && hit[2]) begin
      trim_ff <= wbyte;
    end
  end

  // ****************************************************************
  // Clock failure detection and fallback
  // ****************************************************************
  // Sticky until reset, even if the detector level drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fallback_ff <= 1'b0;
      fail_flag_ff <= 1'b0;
    end else if (detect_fuse_s && fail_s) begin
      fallback_ff <= 1'b1;
      fail_flag_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_ie_ff <= 1'b0;
    end else if (wr_done && hit[1] && wbyte[`SCP_FAIL_IE_BIT]) begin
      fail_ie_ff <= 1'b1;
    end
  end

  assign osc_fail_req = fail_flag_ff & fail_ie_ff;

  // ****************************************************************
  // Timer oscillator control
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tosc_en_ff <= 1'b0;
      tosc_ext_ff <= 1'b0;
    end else if (wr_done && hit[3]) begin
      tosc_en_ff <= wbyte[`SCP_TMR_OSC_EN_BIT];
      tosc_ext_ff <= wbyte[`SCP_TMR_EXT_CLK_BIT];
    end
  end

  // Timer pins shared with the external clock input
  logic rc_is_source;
  assign rc_is_source = fallback_ff || (src_fuse_s == `SCP_SRC_RC);

  // ****************************************************************
  // Oscillator control outputs
  // ****************************************************************
  always_comb begin
    osc_ctrl.clk_src_sel = fallback_ff ? `SCP_SRC_RC : src_fuse_s;
    osc_ctrl.fallback_active = fallback_ff;
    osc_ctrl.lf_osc_enable = detect_fuse_s;
    osc_ctrl.rc_trim = trim_ff;
    osc_ctrl.timer_osc_enable = tosc_en_ff && rc_is_source;
    osc_ctrl.timer_osc_ext_clk = tosc_ext_ff && tosc_en_ff &&
                                 rc_is_source;
  end

endmodule
`default_nettype wire

// File: verif/scp_clock_ctrl_props.sv
// Port assertions for the clock prescale block
`timescale 1ns/1ps
`default_nettype none
module scp_clock_ctrl_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire scp_pkg::scp_fuse_t fuses, // Fuse levels
  input wire logic [7:0] factory_trim, // Factory trim
  input wire logic ext_clk_fail, // Detector level
  input wire logic io_out, // Port value
  input wire logic io_oe, // Port enable
  input wire logic clock_out_pin_o, // Pin value
  input wire logic clock_out_pin_oe, // Pin enable
  input wire scp_pkg::scp_osc_ctrl_t osc_ctrl, // Oscillator controls
  input wire logic osc_fail_req // Failure request
);
  // ****************************************************************
  // Edges since reset release
  // ****************************************************************
  logic [2:0] rel_cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_cnt_ff <= 3'h0;
    end else if (rel_cnt_ff != 3'h4) begin
      rel_cnt_ff <= rel_cnt_ff + 3'h1;
    end
  end
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence fail_held;
    (ext_clk_fail && fuses.fail_detect_fuse)[*2];
  endsequence
  sequence fuse_held;
    (fuses.fail_detect_fuse)[*3];
  endsequence
  pin_oe_fuse_a: assert property (
    fuses.clock_output_fuse |-> clock_out_pin_oe)
    else $error("pin enable low with fuse set");
  pin_io_pass_a: assert property (
    !fuses.clock_output_fuse |->
    (clock_out_pin_o == io_out) && (clock_out_pin_oe == io_oe))
    else $error("pin not handed to port logic");
  fall_entry_a: assert property (
    fail_held |-> ##[1:4] osc_ctrl.fallback_active)
    else $error("no fallback after failure");
  fall_source_a: assert property (
    osc_ctrl.fallback_active |-> osc_ctrl.clk_src_sel == 4'h2)
    else $error("fallback not on rc source");
  fall_hold_a: assert property (
    osc_ctrl.fallback_active |=> osc_ctrl.fallback_active)
    else $error("fallback left before reset");
  fail_req_hold_a: assert property (
    osc_fail_req |=> osc_fail_req)
    else $error("failure request dropped");
  lf_osc_on_a: assert property (
    fuse_held |-> osc_ctrl.lf_osc_enable)
    else $error("slow oscillator off with fuse set");
  trim_load_a: assert property (
    rel_cnt_ff == 3'h3 |-> osc_ctrl.rc_trim == factory_trim)
    else $error("trim not loaded from factory value");
  timer_rc_only_a: assert property (
    osc_ctrl.timer_osc_enable |-> osc_ctrl.clk_src_sel == 4'h2)
    else $error("timer oscillator on without rc source");
endmodule
`default_nettype wire

// File: verif/test_scp_clock_ctrl.sv
// Self-checking bench for the clock prescale block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h want %h", $time, (a), (b)); end end
module test_scp_clock_ctrl;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  scp_pkg::scp_fuse_t fuses = '{1'b1, 1'b1, 1'b1, 4'h0};
  logic ext_clk_fail = 0;
  logic io_out = 0;
  logic io_oe = 0;
  logic clock_out_pin_o;
  logic clock_out_pin_oe;
  logic sys_clk_en;
  scp_pkg::scp_osc_ctrl_t osc_ctrl;
  logic osc_fail_req;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] r;
  int p;
  localparam logic [7:0] FT = 8'hA5;
  localparam logic [11:0] A_DIV = 12'h184;
  localparam logic [11:0] A_FAIL = 12'h188;
  localparam logic [11:0] A_TRIM = 12'h198;
  localparam logic [11:0] A_TMR = 12'h1A8;
  logic [7:0] fac_trim = FT;

  scp_clock_ctrl u_scp_clock_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fuses(fuses), .factory_trim(fac_trim), .ext_clk_fail(ext_clk_fail),
    .io_out(io_out), .io_oe(io_oe), .clock_out_pin_o(clock_out_pin_o),
    .clock_out_pin_oe(clock_out_pin_oe), .sys_clk_en(sys_clk_en),
    .osc_ctrl(osc_ctrl), .osc_fail_req(osc_fail_req));

  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // ****************************************************************
  // Bus and measurement tasks
  // ****************************************************************
  task summarize();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Entered right after an edge; request held until pready
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
           output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, d, x, e);
  endtask
  task rdr(input logic [11:0] a);
    logic e;
    apb(1'b0, a, 8'h00, r, e);
  endtask
  task set_div(input logic [3:0] c);
    wr(A_DIV, 8'h80);
    wr(A_DIV, {4'h0, c});
    idle();
  endtask
  // Cycles between two divided clock enables
  task per();
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (sys_clk_en !== 1'b1 && k < 600);
    p = 0;
    do begin
      @(posedge pclk);
      p++;
    end while (sys_clk_en !== 1'b1 && p < 600);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset();
    rdr(A_DIV);
    `CHK(r, 32'h0000_0003)
    rdr(A_TRIM);
    idle();
    `CHK(r, {24'h00_0000, FT})
    per();
    per();
    `CHK(p, 8)
    $display("reset values done");
  endtask
  task t_div();
    for (int c = 0; c < 9; c++) begin
      set_div(c[3:0]);
      rdr(A_DIV);
      idle();
      `CHK(r, {28'h000_0000, c[3:0]})
      per();
      `CHK(p, 1 << c)
      per();
      `CHK(p, 1 << c)
    end
    set_div(4'hF);
    rdr(A_DIV);
    idle();
    `CHK(r, 32'h0000_000F)
    per();
    per();
    `CHK(p, 256)
    $display("division codes done");
  endtask
  task t_lock();
    set_div(4'h2);
    wr(A_DIV, 8'h01);
    wr(A_DIV, 8'h81);
    wr(A_DIV, 8'h01);
    rdr(A_DIV);
    `CHK(r, 32'h0000_0002)
    wr(A_DIV, 8'h80);
    rdr(A_DIV);
    `CHK(r, 32'h0000_0082)
    rdr(A_DIV);
    `CHK(r, 32'h0000_0002)
    wr(A_DIV, 8'h80);
    wr(A_DIV, 8'h80);
    wr(A_DIV, 8'h01);
    rdr(A_DIV);
    idle();
    `CHK(r, 32'h0000_0002)
    $display("unlock window done");
  endtask
  task t_trim();
    logic e;
    wr(A_TRIM, 8'h7F);
    rdr(A_TRIM);
    `CHK(r, 32'h0000_007F)
    `CHK(osc_ctrl.rc_trim, 8'h7F)
    wr(A_TRIM, 8'h80);
    apb(1'b0, 12'h1FC, 8'h00, r, e);
    idle();
    `CHK(osc_ctrl.rc_trim, 8'h80)
    `CHK({e, r}, 33'h1_0000_0000)
    $display("trim and unmapped done");
  endtask
  task t_pin();
    int hi;
    hi = 0;
    per();
    `CHK(p, 4)
    fuses.clock_output_fuse <= 1'b0;
    io_out <= 1'b1;
    io_oe <= 1'b1;
    @(posedge pclk);
    `CHK({clock_out_pin_o, clock_out_pin_oe}, 2'h3)
    io_oe <= 1'b0;
    fuses.clock_output_fuse <= 1'b1;
    @(posedge pclk);
    `CHK(clock_out_pin_oe, 1'b1)
    repeat (8) begin
      @(posedge pclk);
      hi += clock_out_pin_o;
    end
    `CHK(hi, 4)
    $display("clock pin done");
  endtask
  task t_fail();
    wr(A_TMR, 8'h03);
    rdr(A_TMR);
    idle();
    `CHK(r, 32'h0000_0003)
    `CHK(osc_ctrl.timer_osc_enable, 1'b0)
    `CHK(osc_ctrl.lf_osc_enable, 1'b1)
    ext_clk_fail <= 1'b1;
    repeat (6) @(posedge pclk);
    `CHK({osc_ctrl.fallback_active, osc_ctrl.clk_src_sel}, 5'h12)
    `CHK(osc_ctrl.timer_osc_enable, 1'b1)
    `CHK(osc_ctrl.timer_osc_ext_clk, 1'b1)
    rdr(A_FAIL);
    `CHK(r, 32'h0000_0002)
    `CHK(osc_fail_req, 1'b0)
    wr(A_FAIL, 8'h01);
    wr(A_FAIL, 8'h00);
    rdr(A_FAIL);
    idle();
    `CHK(r, 32'h0000_0003)
    `CHK(osc_fail_req, 1'b1)
    ext_clk_fail <= 1'b0;
    repeat (5) @(posedge pclk);
    `CHK(osc_ctrl.fallback_active, 1'b1)
    $display("failure fallback done");
  endtask
  task t_reset2();
    fuses.divide_by_eight_fuse <= 1'b0;
    fac_trim <= 8'h3C;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    rdr(A_DIV);
    `CHK(r, 32'h0000_0000)
    rdr(A_FAIL);
    `CHK(r, 32'h0000_0000)
    rdr(A_TRIM);
    idle();
    `CHK(r, 32'h0000_003C)
    `CHK(osc_ctrl.fallback_active, 1'b0)
    $display("second reset done");
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    `CHK(clock_out_pin_oe, 1'b1)
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    t_reset();
    t_div();
    t_lock();
    t_trim();
    t_pin();
    t_fail();
    t_reset2();
    summarize();
  end
endmodule
bind scp_clock_ctrl scp_clock_ctrl_props u_props (.pclk(pclk),
  .presetn(presetn), .fuses(fuses), .factory_trim(factory_trim),
  .ext_clk_fail(ext_clk_fail), .io_out(io_out), .io_oe(io_oe),
  .clock_out_pin_o(clock_out_pin_o), .clock_out_pin_oe(clock_out_pin_oe),
  .osc_ctrl(osc_ctrl), .osc_fail_req(osc_fail_req));
`default_nettype wire
